/* smf_core.sv */
// Purpose: transmit/receive fifos and interrupts of a serial master
// Assumes: host strobes are one-cycle pulses synchronous to core_clk
// Notes:   shifter, baud and frame formats live outside this block
// Operation
// - two sixteen-entry flip-flop fifos
// - each entry is 32 bits wide
// - received frames stored aligned to bit zero
// - one frame per entry, upper bits ignored
// - fifos empty when disabled or reset
// - data write pushes, shifter pops transmit
// - data read pops, shifter loads receive
// - tx empty while count at or below threshold
// - rx full at threshold plus one or more
// - write to full tx sets overflow
// - load to full rx drops, sets overflow
// - read of empty rx returns zero, underflow
// - contention sets sticky master interrupt
// - combined request ORs masked interrupts
// - each maskable, level, active high
// - frame size from control bits 20:16
// - legacy bits 3:0 ignored
// - frame size plus one low data bits meaningful, up to 32
// - disabled means no transfer, clock idle
`timescale 1ns/1ps
`default_nettype none
`include "smf_cfg.svh"
module smf_core (
    input  wire logic                 core_clk,
    input  wire logic                 reset_n,
    input  wire logic                 clkEn,
    input  wire logic                 enable,
    input  wire logic [31:0]          mainControl,
    input  wire logic [`SMF_THR_W-1:0] txThreshold,
    input  wire logic [`SMF_THR_W-1:0] rxThreshold,
    input  wire logic [`SMF_IRQ_W-1:0] irqMask,
    input  wire logic                 dataWrite,
    input  wire logic [31:0]          dataWrData,
    input  wire logic                 dataRead,
    output logic      [31:0]          dataRdData,
    input  wire logic                 txOverflowClear,
    input  wire logic                 rxOverflowClear,
    input  wire logic                 rxUnderflowClear,
    input  wire logic                 contentionClear,
    input  wire logic                 slaveSelectedBusy,
    input  wire logic                 shiftTxPop,
    output logic      [31:0]          shiftTxData,
    output logic                      shiftTxValid,
    input  wire logic                 shiftRxLoad,
    input  wire logic [31:0]          shiftRxData,
    output logic      [4:0]           frameSize,
    output logic                      frameSizeOk,
    output logic                      shiftAllowed,
    output logic      [`SMF_CNT_W-1:0] txLevel,
    output logic      [`SMF_CNT_W-1:0] rxLevel,
    output logic      [`SMF_IRQ_W-1:0] irqRaw,
    output logic      [`SMF_IRQ_W-1:0] irqStatus,
    output logic                      irqCombined
);
    smf_fifo_if txIf ();
    smf_fifo_if rxIf ();

    // ------------------------------------------------------------
    // fifos
    // ------------------------------------------------------------
    smf_fifo u_tx (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .clkEn    (clkEn),
        .port     (txIf)
    );
    smf_fifo u_rx (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .clkEn    (clkEn),
        .port     (rxIf)
    );

    assign txIf.clear  = ~enable;
    assign rxIf.clear  = ~enable;
    assign txIf.push   = dataWrite & enable;
    assign txIf.wrData = dataWrData;
    assign txIf.pop    = shiftTxPop & enable;
    assign rxIf.push   = shiftRxLoad & enable;
    // stored as delivered, bit zero aligned
    assign rxIf.wrData = shiftRxData;
    assign rxIf.pop    = dataRead;
    assign txLevel     = txIf.level;
    assign rxLevel     = rxIf.level;

    // ------------------------------------------------------------
    // shifter side
    // ------------------------------------------------------------
    // no transfer while disabled
    assign shiftAllowed = enable;
    assign shiftTxValid = enable & ~txIf.empty;
    // whole entry offered, shifter uses low bits only
    assign shiftTxData  = txIf.rdData;
    assign frameSize    = mainControl[`SMF_DFS_MSB:`SMF_DFS_LSB];
    assign frameSizeOk  = frameSize >= `SMF_DFS_MIN;

    // ------------------------------------------------------------
    // host read data
    // ------------------------------------------------------------
    // zero on empty read
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            dataRdData <= 32'h0000_0000;
        end else if (clkEn && dataRead) begin
            dataRdData <= rxIf.empty ? 32'h0000_0000 : rxIf.rdData;
        end
    end

    // ------------------------------------------------------------
    // interrupts
    // ------------------------------------------------------------
    logic       txOver;
    logic       rxOver;
    logic       rxUnder;
    logic       contend;
    wire logic  setTxOver  = dataWrite & enable & txIf.full;
    wire logic  setRxOver  = shiftRxLoad & enable & rxIf.full;
    wire logic  setRxUnder = dataRead & rxIf.empty;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            txOver  <= 1'b0;
            rxOver  <= 1'b0;
            rxUnder <= 1'b0;
            contend <= 1'b0;
        end else if (clkEn) begin
            txOver  <= setTxOver  | (txOver  & ~txOverflowClear);
            rxOver  <= setRxOver  | (rxOver  & ~rxOverflowClear);
            rxUnder <= setRxUnder | (rxUnder & ~rxUnderflowClear);
            contend <= slaveSelectedBusy | (contend & ~contentionClear);
        end
    end

    wire logic txeLevel = txIf.level <= {1'b0, txThreshold};
    wire logic rxfLevel = rxIf.level >= {1'b0, rxThreshold} + 5'h01;

    always_comb begin
        irqRaw                = '0;
        irqRaw[`SMF_IRQ_TXE] = txeLevel;
        irqRaw[`SMF_IRQ_TXO] = txOver;
        irqRaw[`SMF_IRQ_RXU] = rxUnder;
        irqRaw[`SMF_IRQ_RXO] = rxOver;
        irqRaw[`SMF_IRQ_RXF] = rxfLevel;
        irqRaw[`SMF_IRQ_MST] = contend;
    end

    assign irqStatus   = irqRaw & irqMask;
    assign irqCombined = |irqStatus;
endmodule : smf_core
`default_nettype wire

/* smf_cfg.svh */
// Purpose: constants for the serial master fifo and interrupt block
// Assumes: 40 MHz core clock
// Notes:   widths and depths are fixed
`ifndef SMF_CFG_SVH
`define SMF_CFG_SVH
`define SMF_DEPTH        16
`define SMF_PTR_W        4
`define SMF_CNT_W        5
`define SMF_DATA_W       32
`define SMF_THR_W        4
`define SMF_DFS_LSB      16
`define SMF_DFS_MSB      20
`define SMF_LEGACY_MSB   3
`define SMF_DFS_MIN      5'h3
`define SMF_IRQ_W        6
`define SMF_IRQ_TXE      0
`define SMF_IRQ_TXO      1
`define SMF_IRQ_RXU      2
`define SMF_IRQ_RXO      3
`define SMF_IRQ_RXF      4
`define SMF_IRQ_MST      5
`endif

/* smf_pkg.sv */
// Purpose: shared types of the serial master fifo block
// Assumes: smf_cfg.svh constants
// Notes:   none
`include "smf_cfg.svh"
package smf_pkg;
    typedef logic [`SMF_DATA_W-1:0] smf_word_t;
    typedef logic [`SMF_CNT_W-1:0]  smf_cnt_t;
    typedef logic [`SMF_IRQ_W-1:0]  smf_irq_t;
endpackage : smf_pkg

/* smf_fifo_if.sv */
// Purpose: push/pop bundle between the top and one fifo
// Assumes: single clock
// Notes:   pop data is valid while empty is low
`timescale 1ns/1ps
`default_nettype none
interface smf_fifo_if;
    logic               push;
    logic               pop;
    logic               clear;
    smf_pkg::smf_word_t wrData;
    smf_pkg::smf_word_t rdData;
    smf_pkg::smf_cnt_t  level;
    logic               full;
    logic               empty;
    modport owner (output push, output pop, output clear, output wrData,
                   input rdData, input level, input full, input empty);
    modport store (input push, input pop, input clear, input wrData,
                   output rdData, output level, output full, output empty);
endinterface : smf_fifo_if
`default_nettype wire

/* smf_fifo.sv */
// Purpose: sixteen-entry, 32-bit flip-flop fifo
// Assumes: nothing of the caller; push on full and pop on empty are ignored inside the fifo
// Notes:   clear empties it in one cycle
`timescale 1ns/1ps
`default_nettype none
`include "smf_cfg.svh"
module smf_fifo (
    input  wire logic   core_clk,
    input  wire logic   reset_n,
    input  wire logic   clkEn,
    smf_fifo_if.store   port
);
    smf_pkg::smf_word_t         mem [`SMF_DEPTH];
    logic [`SMF_PTR_W-1:0]      wrPtr;
    logic [`SMF_PTR_W-1:0]      rdPtr;
    smf_pkg::smf_cnt_t          count;
    wire logic                  doPush = port.push & ~port.full;
    wire logic                  doPop  = port.pop & ~port.empty;

    assign port.rdData = mem[rdPtr];
    assign port.level  = count;
    assign port.full   = count == `SMF_CNT_W'(`SMF_DEPTH);
    assign port.empty  = count == '0;

    always_ff @(posedge core_clk) begin
        if (clkEn && doPush && !port.clear) begin
            mem[wrPtr] <= port.wrData;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else if (clkEn) begin
            if (port.clear) begin
                wrPtr <= '0;
                rdPtr <= '0;
                count <= '0;
            end else begin
                if (doPush) wrPtr <= wrPtr + 1'b1;
                if (doPop)  rdPtr <= rdPtr + 1'b1;
                count <= count + smf_pkg::smf_cnt_t'(doPush) - smf_pkg::smf_cnt_t'(doPop);
            end
        end
    end
endmodule : smf_fifo
`default_nettype wire

/* smf_core_assertions.sv */
// Purpose: port checks for smf_core
// Assumes: one clock, async active-low reset
// Notes:   bound to every smf_core
`timescale 1ns/1ps
`default_nettype none
module smf_core_assertions (
    input wire logic        core_clk,
    input wire logic        reset_n,
    input wire logic        clkEn,
    input wire logic        enable,
    input wire logic [3:0]  txThreshold,
    input wire logic [3:0]  rxThreshold,
    input wire logic [5:0]  irqMask,
    input wire logic        dataWrite,
    input wire logic        dataRead,
    input wire logic [31:0] dataRdData,
    input wire logic        slaveSelectedBusy,
    input wire logic        shiftTxPop,
    input wire logic        shiftRxLoad,
    input wire logic [4:0]  txLevel,
    input wire logic [4:0]  rxLevel,
    input wire logic [5:0]  irqRaw,
    input wire logic [5:0]  irqStatus,
    input wire logic        irqCombined
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    property p_txe; irqRaw[0] == (txLevel <= txThreshold); endproperty
    a_txe: assert property (p_txe) else $error("txe level");
    property p_rxf; irqRaw[4] == (rxLevel >= rxThreshold + 1); endproperty
    a_rxf: assert property (p_rxf) else $error("rxf level");
    property p_mask; irqStatus == (irqRaw & irqMask); endproperty
    a_mask: assert property (p_mask) else $error("mask");
    property p_comb; irqCombined == |irqStatus; endproperty
    a_comb: assert property (p_comb) else $error("combined");
    property p_txo;
        dataWrite && enable && clkEn && !shiftTxPop && txLevel == 16 |=> irqRaw[1];
    endproperty
    a_txo: assert property (p_txo) else $error("txo");
    property p_rxo;
        shiftRxLoad && enable && clkEn && !dataRead && rxLevel == 16 |=> irqRaw[3];
    endproperty
    a_rxo: assert property (p_rxo) else $error("rxo");
    property p_rxu; dataRead && clkEn && rxLevel == 0 |=> irqRaw[2] && dataRdData == 0; endproperty
    a_rxu: assert property (p_rxu) else $error("rxu");
    property p_dis; !enable && clkEn |=> txLevel == 0 && rxLevel == 0; endproperty
    a_dis: assert property (p_dis) else $error("disable");
    property p_mst; slaveSelectedBusy && clkEn |=> irqRaw[5]; endproperty
    a_mst: assert property (p_mst) else $error("contention");
    property p_push;
        dataWrite && enable && clkEn && !shiftTxPop && txLevel < 16 |=> txLevel == $past(txLevel) + 1;
    endproperty
    a_push: assert property (p_push) else $error("push");
    c_txo: cover property (irqRaw[1]);
    c_rxo: cover property (irqRaw[3]);
    c_comb: cover property (irqCombined);
endmodule : smf_core_assertions
bind smf_core smf_core_assertions smf_core_assertions_inst (.*);
`default_nettype wire

/* smf_shift_model.sv */
// Purpose: shift-side partner, loops popped frames back
// Assumes: pop answered in the cycle valid is seen
// Notes:   popOn low stalls the transmit side
`timescale 1ns/1ps
`default_nettype none
module smf_shift_model (
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    input  wire logic        popOn,
    input  wire logic [4:0]  frameSize,
    input  wire logic        shiftTxValid,
    input  wire logic [31:0] shiftTxData,
    output logic             shiftTxPop,
    output logic             shiftRxLoad,
    output logic      [31:0] shiftRxData
);
    logic [31:0] frameMask;
    assign frameMask = 32'hFFFF_FFFF >> (5'h1f - frameSize);
    assign shiftTxPop = popOn & shiftTxValid;
    // frame aligned to bit zero; data toggles while not valid
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            shiftRxLoad <= 1'b0;
            shiftRxData <= 32'h0000_0000;
        end else begin
            shiftRxLoad <= shiftTxPop;
            shiftRxData <= shiftTxPop ? (shiftTxData & frameMask) : ~shiftRxData;
        end
    end
endmodule : smf_shift_model
`default_nettype wire

/* testbench.sv */
// Purpose: self-checking bench for smf_core
// Assumes: inputs change on falling edges
// Notes:   partner loops transmit frames into receive
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic core_clk = 0, reset_n = 0, clkEn = 1, enable = 1, popOn = 0;
    logic dataWrite = 0, dataRead = 0, slaveSelectedBusy = 0;
    logic txOverflowClear = 0, rxOverflowClear = 0, rxUnderflowClear = 0, contentionClear = 0;
    logic shiftTxPop, shiftTxValid, shiftRxLoad, frameSizeOk, shiftAllowed, irqCombined;
    logic [31:0] mainControl = 32'h0007_000F, dataWrData = 32'h0000_0000;
    logic [31:0] dataRdData, shiftTxData, shiftRxData, d;
    logic [3:0]  txThreshold = 4'h3, rxThreshold = 4'hF;
    logic [5:0]  irqMask = 6'h3F, irqRaw, irqStatus;
    logic [4:0]  frameSize, txLevel, rxLevel;
    int          errors = 0, samples_checked = 0;
    smf_core smf_core_inst (.*);
    smf_shift_model smf_shift_model_inst (.*);
    always #12.5 core_clk = ~core_clk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [31:0] v);
        @(negedge core_clk);
        dataWrite = 1'b1;
        dataWrData = v;
        @(negedge core_clk);
        dataWrite = 1'b0;
    endtask : wr
    task automatic rd();
        @(negedge core_clk);
        dataRead = 1'b1;
        @(negedge core_clk);
        dataRead = 1'b0;
        d = dataRdData;
    endtask : rd
    task automatic clr(input logic [3:0] v);
        @(negedge core_clk);
        {contentionClear, rxUnderflowClear, rxOverflowClear, txOverflowClear} = v;
        @(negedge core_clk);
        {contentionClear, rxUnderflowClear, rxOverflowClear, txOverflowClear} = 4'h0;
    endtask : clr
    task automatic t_loop();
        popOn = 1'b1;
        wr(32'hA5A5_1234);
        repeat (3) @(negedge core_clk);
        chk(rxLevel, 5'h01);
        rd();
        chk(d, 32'h0000_0034);
        chk(frameSize, 5'h07);
        chk(frameSizeOk, 1'b1);
        mainControl = 32'h0002_0000;
        @(negedge core_clk);
        chk(frameSize, 5'h02);
        chk(frameSizeOk, 1'b0);
    endtask : t_loop
    task automatic t_fifo();
        popOn = 1'b0;
        mainControl = 32'h001F_0000;
        for (int i = 1; i <= 17; i++) begin
            wr(32'hF000_0000 | i);
            if (i == 3) chk(irqRaw[0], 1'b1);
            if (i == 4) chk(irqRaw[0], 1'b0);
        end
        chk(txLevel, 5'h10);
        chk(shiftTxData, 32'hF000_0001);
        chk(shiftTxValid, 1'b1);
        chk(irqRaw[1], 1'b1);
        clr(4'h1);
        chk(irqRaw[1], 1'b0);
        popOn = 1'b1;
        repeat (20) @(negedge core_clk);
        chk(irqRaw[4], 1'b1);
        wr(32'hDEAD_BEEF);
        repeat (3) @(negedge core_clk);
        chk(irqRaw[3], 1'b1);
        for (int i = 1; i <= 16; i++) begin
            rd();
            chk(d, 32'hF000_0000 | i);
            if (i == 1) chk(irqRaw[4], 1'b0);
        end
        rd();
        chk(d, 32'h0000_0000);
        chk(irqRaw[2], 1'b1);
        clr(4'h6);
        chk(irqRaw[3:2], 2'h0);
    endtask : t_fifo
    task automatic t_dis();
        popOn = 1'b0;
        wr(32'h0000_0001);
        enable = 1'b0;
        wr(32'h0000_0002);
        chk(txLevel, 5'h00);
        chk(shiftAllowed, 1'b0);
        chk(shiftTxValid, 1'b0);
        enable = 1'b1;
        clkEn = 1'b0;
        wr(32'h0000_0003);
        chk(txLevel, 5'h00);
        clkEn = 1'b1;
    endtask : t_dis
    task automatic t_irq();
        slaveSelectedBusy = 1'b1;
        @(negedge core_clk);
        slaveSelectedBusy = 1'b0;
        @(negedge core_clk);
        chk(irqRaw[5], 1'b1);
        for (int b = 0; b < 6; b++) begin
            irqMask = 6'h01 << b;
            @(negedge core_clk);
            chk(irqCombined, b == 0 || b == 5);
            chk(irqStatus, (b == 0 || b == 5) ? (32'h0000_0001 << b) : 32'h0000_0000);
        end
        clr(4'h8);
        chk(irqRaw[5], 1'b0);
    endtask : t_irq
    task automatic results();
        $display("errors %0d, samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : results
    initial begin
        repeat (12) @(negedge core_clk);
        reset_n = 1'b1;
        chk(irqRaw, 6'h01);
        t_loop();
        t_fifo();
        t_dis();
        t_irq();
        results();
    end
    initial begin
        #50000;
        errors++;
        results();
    end
endmodule : testbench
`default_nettype wire
